// ===== verilog/brew_panel_map.svh
/*
 Offsets, reset values and timing counts of the panel controller.
 Assumes a 20 MHz clock and a 32-bit classic Wishbone register bus.
*/
`ifndef BREW_PANEL_MAP_SVH
`define BREW_PANEL_MAP_SVH
// ----------------------------------------
// Clock and times
// ----------------------------------------
`define CLK_HZ 20000000
`define HOLD_S 5
`define HOLD_CYC (`HOLD_S * `CLK_HZ)
`define REVERT_S 2
`define REVERT_CYC (`REVERT_S * `CLK_HZ)
`define ALT_S 1
`define ALT_CYC (`ALT_S * `CLK_HZ)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_SETPOINT 4'h0
`define REG_MANPOW 4'h4
`define REG_STATUS 4'h8
// ----------------------------------------
// Values
// ----------------------------------------
`define SETPOINT_RST 16'h0098
`define POWER_FULL 7'h64
`define PWM_LAST 7'h63
`endif

// ===== verilog/brew_panel_pkg.sv
/*
 Types of the panel controller: menu states and display words.
 Assumes the map header for all numbers.
*/
package brew_panel_pkg;
    typedef enum logic [2:0] {
        NORMAL, M_LEAVE, M_RESET, M_HOLDMODE, M_MANUAL, PARAM
    } menu_t;
    typedef enum logic [3:0] {
        G_TEMP, G_TIMER, G_PROBE_MISSING, G_RESET_TITLE, G_NO, G_YES,
        G_MODE_TITLE, G_INFUSE, G_BOIL, G_SETPOINT, G_POWER, G_PARAM
    } glyph_t;
    typedef struct packed {
        glyph_t g;
        logic [15:0] v;
    } disp_t;
endpackage : brew_panel_pkg

// ===== verilog/brew_panel_menu_controller.sv
/*
 Front-panel logic of a heater power regulator: knob decode, menu,
 displays, lamps and the relay drive.
 Assumes temperature, timer and regulated power come from same-clock
 logic; knob and sensor-present arrive as raw pins.
*/
// The address map and the Wishbone slave port are this design's own decisions.
`include "brew_panel_map.svh"
module brew_panel_menu_controller import brew_panel_pkg::*; #(
    parameter int HOLD_CYC = `HOLD_CYC,
    parameter int REVERT_CYC = `REVERT_CYC,
    parameter int ALT_CYC = `ALT_CYC,
    parameter int ACC_W = 28
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic knob_a_i,
    input wire logic knob_b_i,
    input wire logic knob_press_i,
    input wire logic sensor_ok_i,
    input wire logic [15:0] temp_i,
    input wire logic timer_active_i,
    input wire logic [15:0] timer_val_i,
    input wire logic [6:0] auto_power_i,
    input wire logic nv_mode_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output disp_t top_o,
    output disp_t bottom_o,
    output logic mode_lamp_o,
    output logic drive_lamp_o,
    output logic adj_dot_o,
    output logic ssr_o,
    output logic timer_reset_o,
    output logic param_mode_o,
    output logic mode_save_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic a1, a2, b1, b2, p1, p2, k1, k2;
        logic a_old, p_old, held, boot;
        menu_t menu;
        logic mode;
        logic [15:0] setpoint, pend;
        logic editing;
        logic [31:0] idle, hold, alt;
        logic [6:0] man_pow, power, pwm;
        logic [ACC_W-1:0] acc;
        disp_t top, bottom;
        logic mode_lamp, drive_lamp, adj_dot, ssr, treset, param;
        logic [31:0] dat;
        logic ack;
    } st_t;

    st_t s, n;

    function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
        wr16 = old;
        if (sel[0]) wr16[7:0] = d[7:0];
        if (sel[1]) wr16[15:8] = d[15:8];
    endfunction : wr16

    function automatic logic [6:0] step7(input logic [6:0] v, input logic up,
                                         input logic [6:0] top);
        if (up) step7 = (v < top) ? v + 7'h01 : v;
        else step7 = (v != 7'h00) ? v - 7'h01 : v;
    endfunction : step7

    logic click, cw, ccw, short_press, wb_req;
    assign click = s.a2 && !s.a_old;
    assign cw = click && !s.b2;
    assign ccw = click && s.b2;
    assign short_press = !s.p2 && s.p_old && !s.held;
    assign wb_req = wb_cyc_i && wb_stb_i && !s.ack;

    always_comb begin
        n = s;
        // Two flops on each knob pin and on the sensor pin before use
        n.a1 = knob_a_i;
        n.a2 = s.a1;
        n.b1 = knob_b_i;
        n.b2 = s.b1;
        n.p1 = knob_press_i;
        n.p2 = s.p1;
        n.k1 = sensor_ok_i;
        n.k2 = s.k1;
        n.a_old = s.a2;
        n.p_old = s.p2;
        n.treset = 1'b0;
        if (!s.boot) begin
            n.boot = 1'b1;
            n.mode = nv_mode_i;
            n.setpoint = `SETPOINT_RST;
            n.pend = `SETPOINT_RST;
        end
        // ----------------------------------------
        // Press timing
        // ----------------------------------------
        if (s.p2 && !s.p_old) begin
            n.held = 1'b0;
            n.hold = 32'h0;
        end else if (s.p2 && !s.held) begin
            n.hold = s.hold + 32'h1;
        end
        if (s.p2 && !s.held && s.hold == 32'(HOLD_CYC - 1) && s.menu == NORMAL) begin
            n.held = 1'b1;
            n.menu = PARAM;
            n.editing = 1'b0;
            n.pend = s.setpoint;
        end
        // ----------------------------------------
        // Menu
        // ----------------------------------------
        unique case (s.menu)
            NORMAL: begin
                if (short_press && s.editing) begin
                    n.setpoint = s.pend;
                    n.editing = 1'b0;
                end else if (short_press) begin
                    n.menu = M_LEAVE;
                end else if (click && s.mode) begin
                    n.pend = cw ? s.pend + 16'h1 : s.pend - 16'h1;
                    n.editing = 1'b1;
                    n.idle = 32'h0;
                end else if (click) begin
                    n.man_pow = step7(s.man_pow, cw, `POWER_FULL);
                end
            end
            M_LEAVE: begin
                if (short_press) n.menu = NORMAL;
                else if (cw) n.menu = M_RESET;
            end
            M_RESET: begin
                if (short_press) begin
                    n.treset = 1'b1;
                    n.menu = NORMAL;
                end else if (cw) n.menu = M_HOLDMODE;
                else if (ccw) n.menu = M_LEAVE;
            end
            M_HOLDMODE: begin
                if (short_press) begin
                    n.mode = 1'b1;
                    n.menu = NORMAL;
                end else if (cw) n.menu = M_MANUAL;
                else if (ccw) n.menu = M_RESET;
            end
            M_MANUAL: begin
                if (short_press) begin
                    n.mode = 1'b0;
                    n.menu = NORMAL;
                end else if (ccw) n.menu = M_HOLDMODE;
            end
            PARAM: begin
                if (short_press) n.menu = NORMAL;
            end
        endcase
        if (s.editing && n.editing && !click) begin
            n.idle = s.idle + 32'h1;
            if (s.idle == 32'(REVERT_CYC - 1)) begin
                n.editing = 1'b0;
                n.pend = s.setpoint;
            end
        end
        // Software writes override the knob in the same cycle
        n.ack = wb_req;
        n.dat = 32'h0;
        if (wb_req) begin
            unique case (wb_adr_i)
                `REG_SETPOINT: begin
                    n.dat = {16'h0, s.setpoint};
                    if (wb_we_i) begin
                        n.setpoint = wr16(s.setpoint, wb_dat_i, wb_sel_i);
                        n.pend = n.setpoint;
                        n.editing = 1'b0;
                    end
                end
                `REG_MANPOW: begin
                    n.dat = {25'h0, s.man_pow};
                    if (wb_we_i && wb_sel_i[0] && wb_dat_i[6:0] <= `POWER_FULL) n.man_pow = wb_dat_i[6:0];
                end
                `REG_STATUS: n.dat = {16'h0, 1'b0, s.menu, s.mode, s.editing, s.k2, 2'b0, s.power};
                default: n.dat = 32'h0;
            endcase
        end
        // ----------------------------------------
        // Power and relay
        // ----------------------------------------
        // automatic or chosen power
        n.power = s.mode ? auto_power_i : s.man_pow;
        if (!s.k2) n.power = 7'h0;
        n.pwm = (s.pwm == `PWM_LAST) ? 7'h0 : s.pwm + 7'h1;
        n.ssr = s.k2 && (s.pwm < s.power);
        n.acc = s.acc + ACC_W'(s.power);
        if (s.power >= `POWER_FULL) n.drive_lamp = 1'b1;
        else if (s.power == 7'h0) n.drive_lamp = 1'b0;
        else n.drive_lamp = s.acc[ACC_W-1];
        // ----------------------------------------
        // Lamps and displays
        // ----------------------------------------
        n.alt = (s.alt == 32'(ALT_CYC - 1)) ? 32'h0 : s.alt + 32'h1;
        n.mode_lamp = n.mode;
        n.param = n.menu == PARAM;
        n.adj_dot = n.editing && s.alt < 32'(ALT_CYC / 2);
        if (!s.k2) n.top = '{G_PROBE_MISSING, 16'h0};
        else if (timer_active_i && s.alt >= 32'(ALT_CYC / 2)) n.top = '{G_TIMER, timer_val_i};
        else n.top = '{G_TEMP, temp_i};
        n.bottom = s.mode ? '{G_SETPOINT, n.pend} : '{G_POWER, {9'h0, n.man_pow}};
        unique case (n.menu)
            NORMAL: ;
            M_LEAVE: begin
                n.top = '{G_RESET_TITLE, 16'h0};
                n.bottom = '{G_NO, 16'h0};
            end
            M_RESET: begin
                n.top = '{G_RESET_TITLE, 16'h0};
                n.bottom = '{G_YES, 16'h0};
            end
            M_HOLDMODE: begin
                n.top = '{G_MODE_TITLE, 16'h0};
                n.bottom = '{G_INFUSE, 16'h0};
            end
            M_MANUAL: begin
                n.top = '{G_MODE_TITLE, 16'h0};
                n.bottom = '{G_BOIL, 16'h0};
            end
            PARAM: begin
                n.top = '{G_PARAM, 16'h0};
                n.bottom = '{G_PARAM, 16'h0};
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) s <= '0;
        else s <= n;
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign top_o = s.top;
    assign bottom_o = s.bottom;
    assign mode_lamp_o = s.mode_lamp;
    assign drive_lamp_o = s.drive_lamp;
    assign adj_dot_o = s.adj_dot;
    assign ssr_o = s.ssr;
    assign timer_reset_o = s.treset;
    assign param_mode_o = s.param;
    assign mode_save_o = s.mode;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence menu_press(menu_t m);
        s.menu == m && short_press && !wb_req;
    endsequence

    a_hold_enter: assert property (
        s.menu == NORMAL && s.p2 && !s.held && s.hold == 32'(HOLD_CYC - 1) |=> param_mode_o ##1 top_o.g == G_PARAM)
        else $error("long hold did not reach settings");
    a_short_menu: assert property (
        menu_press(NORMAL) ##0 !s.editing |=> s.menu == M_LEAVE && top_o.g == G_RESET_TITLE && bottom_o.g == G_NO)
        else $error("short press did not open menu");
    a_leave_clean: assert property (
        menu_press(M_LEAVE) |=> s.menu == NORMAL && $stable(s.mode) && $stable(s.setpoint) && !timer_reset_o)
        else $error("leave changed state");
    a_reset_pulse: assert property (
        menu_press(M_RESET) |=> timer_reset_o ##1 !timer_reset_o)
        else $error("timer reset pulse wrong");
    a_mode_pick: assert property (
        menu_press(M_MANUAL) |=> !s.mode ##1 !mode_lamp_o)
        else $error("manual mode not taken");
    a_lamp_mode: assert property (
        $rose(s.mode) |=> mode_lamp_o)
        else $error("mode lamp off in holding mode");
    a_drive_full: assert property (
        (s.power == `POWER_FULL) [*2] |=> drive_lamp_o)
        else $error("drive lamp not solid at full");
    a_revert_time: assert property (
        s.editing && !click && !wb_req && s.menu == NORMAL && s.idle == 32'(REVERT_CYC - 1) |=> !s.editing && s.pend == s.setpoint)
        else $error("setpoint did not revert");
    a_cw_power: assert property (
        s.menu == NORMAL && !s.mode && cw && !short_press && !wb_req && s.man_pow < `POWER_FULL
        |=> s.man_pow == $past(s.man_pow) + 7'h01)
        else $error("clockwise click did not raise power");
    a_probe_off: assert property (
        !s.k2 |=> !ssr_o && top_o.g == G_PROBE_MISSING)
        else $error("heater on without probe");
    a_menu_back: assert property (
        s.menu == M_HOLDMODE && ccw && !short_press |=> s.menu == M_RESET)
        else $error("menu did not step back");
    a_boot_mode: assert property (
        !s.boot |=> s.mode == $past(nv_mode_i) && mode_save_o == $past(nv_mode_i))
        else $error("saved mode not restored");
    a_bottom_power: assert property (
        s.boot && s.menu == NORMAL && !s.mode && !s.p2 && !s.p_old |=> bottom_o.g == G_POWER && bottom_o.v[6:0] == s.man_pow)
        else $error("manual bottom display wrong");
endmodule : brew_panel_menu_controller

// ===== verification/brew_knob_model.sv
/*
 Operator at the panel: turns and presses the knob, plugs the probe.
 Assumes the panel clock; pins change just after a rising edge.
*/
module brew_knob_model (
    input wire logic clk_i,
    output logic knob_a_o,
    output logic knob_b_o,
    output logic press_o,
    output logic sensor_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        knob_a_o = 1'b0;
        knob_b_o = 1'b0;
        press_o = 1'b0;
        sensor_ok_o = 1'b1;
    end
    // B settles before A rises, as a real detent does
    task automatic click(input logic cw);
        @(posedge clk_i) knob_b_o <= ~cw;
        repeat (2) @(posedge clk_i);
        knob_a_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        knob_a_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask : click
    task automatic push(input int n);
        @(posedge clk_i) press_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        press_o <= 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask : push
    task automatic probe(input logic ok);
        @(posedge clk_i) sensor_ok_o <= ok;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
    endtask : probe
endmodule : brew_knob_model

// ===== verification/brew_panel_menu_controller_tb.sv
/*
 Self-checking bench of the panel controller: bus, menu, lamps, displays.
 Assumes the operator model on the knob pins and short timing parameters.
*/
module brew_panel_menu_controller_tb import brew_panel_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, knob_a, knob_b, press, probe_ok, timer_active_i, nv_mode_i;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mode_lamp_o, drive_lamp_o, adj_dot_o, ssr_o;
    logic timer_reset_o, param_mode_o, mode_save_o;
    logic [15:0] temp_i, timer_val_i;
    logic [6:0] auto_power_i;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    disp_t top_o, bottom_o;
    int fail_count = 0, samples_checked = 0, pulses = 0, cycles = 0, hs, hl, tg, ha, ht;
    // Short counts; an 8-bit accumulator makes the lamp flash visibly
    brew_panel_menu_controller #(.HOLD_CYC(64), .REVERT_CYC(32), .ALT_CYC(16), .ACC_W(8)) u_dut (
        .clk_i, .rst_i, .knob_a_i(knob_a), .knob_b_i(knob_b), .knob_press_i(press),
        .sensor_ok_i(probe_ok), .temp_i, .timer_active_i, .timer_val_i, .auto_power_i, .nv_mode_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .top_o, .bottom_o, .mode_lamp_o, .drive_lamp_o, .adj_dot_o, .ssr_o, .timer_reset_o,
        .param_mode_o, .mode_save_o);
    brew_knob_model u_knob (.clk_i, .knob_a_o(knob_a), .knob_b_o(knob_b), .press_o(press),
        .sensor_ok_o(probe_ok));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (timer_reset_o === 1'b1)
            pulses++;
        if (cycles == 8000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: saw %0h want %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, input logic [3:0] sel = 4'hF);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(negedge clk_i);
    endtask : wb
    task automatic rdc(input logic [3:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0);
        check(q, exp, what);
    endtask : rdc
    task automatic shows(input glyph_t t, input glyph_t b, input string what);
        check(32'(top_o.g), 32'(t), what);
        check(32'(bottom_o.g), 32'(b), what);
    endtask : shows
    task automatic span(input int n);
        logic last;
        {hs, hl, tg, ha, ht} = '0;
        last = drive_lamp_o;
        repeat (n) begin
            @(negedge clk_i);
            hs += int'(ssr_o === 1'b1);
            hl += int'(drive_lamp_o === 1'b1);
            tg += int'(drive_lamp_o !== last);
            ha += int'(adj_dot_o === 1'b1);
            ht += int'(top_o.g === G_TIMER);
            last = drive_lamp_o;
        end
    endtask : span
    task automatic t_regs;
        check(32'({mode_lamp_o, mode_save_o}), 32'h3, "saved mode");
        wb(1'b1, 4'hC, 32'h0000_FFFF);
        rdc(4'hC, 32'h0, "unmapped");
        rdc(4'h0, 32'h0000_0098, "setpoint");
        wb(1'b1, 4'h0, 32'h0000_5511, 4'h2);
        rdc(4'h0, 32'h0000_5598, "upper lane");
        check(32'(bottom_o.v), 32'h0000_5598, "upper lane shown");
        wb(1'b1, 4'h0, 32'h0000_3300, 4'h1);
        rdc(4'h0, 32'h0000_5500, "lower lane");
        wb(1'b1, 4'h0, 32'h0000_0098, 4'h3);
        wb(1'b1, 4'h4, 32'h0000_0032);
        wb(1'b1, 4'h4, 32'h0000_0065);
        wb(1'b1, 4'h4, 32'h0000_0010, 4'h2);
        rdc(4'h4, 32'h0000_0032, "power over 100");
        rdc(4'h8, 32'h0000_0A2A, "status");
    endtask : t_regs
    task automatic t_menu;
        int n;
        n = pulses;
        u_knob.push(2);
        shows(G_RESET_TITLE, G_NO, "menu open");
        u_knob.push(2);
        shows(G_TEMP, G_SETPOINT, "menu leave");
        check(pulses, n, "stray timer reset");
        u_knob.push(2);
        u_knob.click(1'b1);
        shows(G_RESET_TITLE, G_YES, "confirm item");
        u_knob.push(2);
        check(pulses, n + 1, "timer reset");
    endtask : t_menu
    task automatic t_mode;
        u_knob.push(2);
        repeat (2) u_knob.click(1'b1);
        shows(G_MODE_TITLE, G_INFUSE, "infusion item");
        repeat (2) u_knob.click(1'b1);
        shows(G_MODE_TITLE, G_BOIL, "boil item");
        repeat (2) u_knob.click(1'b0);
        shows(G_RESET_TITLE, G_YES, "stepping back");
        repeat (2) u_knob.click(1'b0);
        shows(G_RESET_TITLE, G_NO, "stop at leave");
        repeat (3) u_knob.click(1'b1);
        u_knob.push(2);
        check(32'({mode_lamp_o, mode_save_o}), 32'h0, "manual lamp");
        check(32'(bottom_o), {12'h0, G_POWER, 16'h0032}, "lettered power");
    endtask : t_mode
    task automatic t_power;
        int pw[4] = '{0, 20, 60, 100};
        int tgs[4];
        u_knob.click(1'b1);
        rdc(4'h4, 32'h0000_0033, "click up");
        wb(1'b1, 4'h4, 32'h0000_0064);
        u_knob.click(1'b1);
        rdc(4'h4, 32'h0000_0064, "saturate");
        u_knob.click(1'b0);
        rdc(4'h4, 32'h0000_0063, "click down");
        foreach (pw[i]) begin
            wb(1'b1, 4'h4, 32'(pw[i]));
            repeat (3) @(negedge clk_i);
            span(100);
            tgs[i] = tg;
            check(hs, pw[i], "ssr duty");
            check(32'(bottom_o.v), pw[i], "power shown");
            if (pw[i] % 100 == 0)
                check(hl, pw[i], "lamp solid or dark");
        end
        check(32'(tgs[2] > tgs[1] && tgs[1] > 0), 32'h1, "flash rate");
    endtask : t_power
    task automatic t_hold;
        u_knob.push(2);
        repeat (2) u_knob.click(1'b1);
        u_knob.push(2);
        check(32'({mode_lamp_o, mode_save_o}), 32'h3, "holding lamp");
        check(32'(bottom_o), {12'h0, G_SETPOINT, 16'h0098}, "setpoint shown");
        @(posedge clk_i) auto_power_i <= 7'h3C;
        repeat (3) @(negedge clk_i);
        span(100);
        check(hs, 60, "regulated power");
        u_knob.click(1'b1);
        check(32'(bottom_o.v), 32'h0000_0099, "edit up");
        span(16);
        check(ha, 8, "dot blinks");
        repeat (40) @(negedge clk_i);
        check(32'({adj_dot_o, bottom_o.v}), 32'h0000_0098, "revert");
        u_knob.click(1'b0);
        u_knob.push(2);
        rdc(4'h0, 32'h0000_0097, "confirmed");
        check(32'(adj_dot_o), 32'h0, "dot off");
    endtask : t_hold
    task automatic t_show;
        @(posedge clk_i) {timer_active_i, timer_val_i, temp_i} <= {1'b1, 16'h0456, 16'h0057};
        repeat (3) @(negedge clk_i);
        span(32);
        check(ht, 16, "timer alternates");
        while (top_o.g !== G_TIMER) @(negedge clk_i);
        check(32'(top_o.v), 32'h0000_0456, "timer value");
        while (top_o.g !== G_TEMP) @(negedge clk_i);
        check(32'(top_o.v), 32'h0000_0057, "temperature");
        @(posedge clk_i) timer_active_i <= 1'b0;
        u_knob.probe(1'b0);
        check(32'(top_o.g), 32'(G_PROBE_MISSING), "probe missing");
        span(100);
        check(hs, 0, "heater off");
        u_knob.probe(1'b1);
        u_knob.push(50);
        check(32'(param_mode_o), 32'h0, "short of hold");
        u_knob.push(2);
        u_knob.push(80);
        check(32'(param_mode_o), 32'h1, "long hold");
        u_knob.push(2);
        check(32'(param_mode_o), 32'h0, "leave settings");
    endtask : t_show
    // Restart in mid-run with manual mode saved
    task automatic t_reboot;
        @(posedge clk_i) {rst_i, nv_mode_i} <= 2'h2;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        check(32'({mode_lamp_o, mode_save_o}), 32'h0, "saved manual mode");
        check(32'(bottom_o), {12'h0, G_POWER, 16'h0000}, "manual after restart");
    endtask : t_reboot
    initial begin
        {clk_i, timer_active_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {rst_i, nv_mode_i} = 2'h3;
        {temp_i, timer_val_i, auto_power_i, wb_sel_i} = {16'h0041, 16'h0123, 7'h2A, 4'hF};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(negedge clk_i);
        t_regs;
        t_menu;
        t_mode;
        t_power;
        t_hold;
        t_show;
        t_reboot;
        tally_and_finish;
    end
endmodule : brew_panel_menu_controller_tb
